/* verilog/ctqr_defines.svh */
`ifndef CTQR_DEFINES_SVH
`define CTQR_DEFINES_SVH

// ==========================================================
// Sub-addresses
`define CTQR_OFS_BP1        8'h1F
`define CTQR_OFS_BP6        8'h24
`define CTQR_OFS_VHI        8'h25
`define CTQR_OFS_VLO        8'h26
`define CTQR_OFS_IHI        8'h27
`define CTQR_OFS_ILO        8'h28
`define CTQR_OFS_CFG        8'h29
`define CTQR_OFS_TOT        8'h30
`define CTQR_OFS_CV         8'h31
`define CTQR_OFS_ABS        8'h32
`define CTQR_OFS_EQ         8'h33
`define CTQR_OFS_FLAGS      8'h34

// ==========================================================
// Field positions
`define CTQR_CFG_CX_BIT     2
`define CTQR_CFG_TCOMP_BIT  1
`define CTQR_CFG_TQ_BIT     0
`define CTQR_FLG_EQ_BIT     10
`define CTQR_FLG_ABS_BIT    9
`define CTQR_FLG_SUSP_BIT   8

// ==========================================================
// Reset values and counts
`define CTQR_RST_CFG        3'h0
`define CTQR_RST_BP         16'h0000
`define CTQR_RST_CODES      15'h0000
`define CTQR_RST_REGION     3'h7
`define CTQR_TIMER_MAX      16'hFFFF
`define CTQR_SYNC_FILL      2'h3
`define CTQR_REGION_COLD    3'h1
`define CTQR_REGION_HOT     3'h7

`endif

/* verilog/ctqr_pkg.sv */
`include "ctqr_defines.svh"

package ctqr_pkg;

   typedef enum logic [1:0] {
      CTQR_LI_ION,
      CTQR_LIFEPO4,
      CTQR_LEAD_ACID
   } ctqr_chem_t;

   typedef struct packed {
      logic [1:0]       chem_meta;
      logic [1:0]       chem;
      logic             vnear_meta;
      logic             vnear;
      logic             sysf_meta;
      logic             sysf;
      logic [1:0]       dflt_cnt;
      logic [5:0][15:0] bp;
      logic [9:0]       vhi;
      logic [14:0]      vlo;
      logic [9:0]       ihi;
      logic [14:0]      ilo;
      logic [2:0]       cfg;
      logic [15:0]      tot;
      logic [15:0]      cv;
      logic [15:0]      abs_t;
      logic [15:0]      eq;
      logic             prev_chg;
      logic             prev_cv;
      logic             prev_abs;
      logic             prev_eq;
      logic [2:0]       region;
      logic             pause;
      logic [4:0]       vcode;
      logic [4:0]       icode;
      logic             tterm;
      logic             mfault;
      logic [10:0]      flags;
      logic [15:0]      rdata;
   } ctqr_state_t;

endpackage

/* verilog/ctqr_regs.sv */
`timescale 1ns/100ps
`include "ctqr_defines.svh"

// How it works
// (R1) Six 16-bit RW break points, 0x1F to 0x24, bound seven regions.
// (R2) Software programs break points descending, coldest highest.
// (R3) Break points ignored for lead-acid or with qualified enable zero.
// (R4) Regions 1 and 7 pause charging; they have no voltage or current code.
// (R5) Voltage codes of regions 6 and 5 packed at bits 9:5 and 4:0.
// (R6) Voltage codes of regions 4, 3, 2 at bits 14:10, 9:5, 4:0.
// (R7) Regions 2..6 with feature on: region voltage code replaces setting.
// (R8) Current codes packed likewise in two registers, 6/5 and 4/3/2.
// (R9) In regions 2..6 with feature on, region current code is the target.
// (R10) Config bit 2 enables low-current termination for lithium, default 0.
// (R11) Config bit 1 enables lead-acid temperature compensation, default 1.
// (R12) Config bit 0 enables qualified charging for lithium, default 1 there.
// (R13) Read-only 16-bit seconds of charging, lithium only.
// (R14) Read-only constant-voltage seconds in bits 10:0, lithium only.
// (R15) Read-only absorb seconds in bits 10:0, iron-phosphate and lead-acid.
// (R16) 16-bit equalization seconds register for lead-acid.
// (R17) 11-bit state word with at most one bit set.
// (R18) Bit 10 while equalizing, bit 9 while in absorb phase.
// (R19) Bit 8 while suspended: low input, software suspend or fault.
// (R20) Lithium timer termination after programmed constant-voltage seconds.
// (R21) Lithium fault when charge seconds exceed the programmed limit.
// (R22) Phase timers tick once a second in phase, clear on entry, saturate.
// (R23) Region chosen each measurement; plain settings used when disabled.

module ctqr_regs (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_rd,
   output      logic [15:0] reg_rdata,
   input  wire logic [1:0]  chem_pins,
   input  wire logic        vin_near_battery_sense_pin,
   input  wire logic        system_fault_pin,
   input  wire logic        suspend_sw,
   input  wire logic [15:0] ntc_ratio,
   input  wire logic        meas_done,
   input  wire logic        sec_tick,
   input  wire logic        phase_charging,
   input  wire logic        phase_cv,
   input  wire logic        phase_absorb,
   input  wire logic        phase_equalize,
   input  wire logic [4:0]  vcharge_setting,
   input  wire logic [4:0]  icharge_target,
   input  wire logic [15:0] const_volt_limit,
   input  wire logic [15:0] max_charge_limit,
   output      logic [2:0]  temp_region,
   output      logic        charge_pause,
   output      logic [4:0]  vcharge_code,
   output      logic [4:0]  icharge_code,
   output      logic        cx_term_en,
   output      logic        temp_comp_en,
   output      logic        timer_term,
   output      logic        max_time_fault,
   output      logic [10:0] charge_phase_flags
);

   // ======================================================
   // State
   ctqr_pkg::ctqr_state_t s;
   ctqr_pkg::ctqr_state_t next_s;
   logic                  is_la;
   logic                  is_lion;
   logic                  jact;

   assign is_la   = ctqr_pkg::ctqr_chem_t'(s.chem) == ctqr_pkg::CTQR_LEAD_ACID;
   assign is_lion = ctqr_pkg::ctqr_chem_t'(s.chem) == ctqr_pkg::CTQR_LI_ION;
   assign jact    = !is_la && s.cfg[`CTQR_CFG_TQ_BIT]; // see (R3) (R12)

   function automatic logic [15:0] step(input logic [15:0] c,
                                        input logic        act,
                                        input logic        prev,
                                        input logic        tick);
      if (act && !prev)
         return 16'h0000;
      if (act && tick && c != `CTQR_TIMER_MAX)
         return c + 16'h0001;
      return c;
   endfunction

   // ======================================================
   // Next state
   always_comb begin
      logic [2:0]  idx;
      logic [2:0]  r;
      logic [4:0]  vsel;
      logic [4:0]  isel;
      idx  = 3'(reg_addr - `CTQR_OFS_BP1);
      r    = `CTQR_REGION_HOT;
      vsel = vcharge_setting;
      isel = icharge_target;
      next_s = s;

      // Pin synchronisers
      next_s.chem_meta  = chem_pins;
      next_s.chem       = s.chem_meta;
      next_s.vnear_meta = vin_near_battery_sense_pin;
      next_s.vnear      = s.vnear_meta;
      next_s.sysf_meta  = system_fault_pin;
      next_s.sysf       = s.sysf_meta;

      // Chemistry defaults once the strap is through the synchroniser
      if (s.dflt_cnt != `CTQR_SYNC_FILL)
         next_s.dflt_cnt = s.dflt_cnt + 2'h1;
      if (s.dflt_cnt == 2'h2) begin
         next_s.cfg = `CTQR_RST_CFG;
         if (ctqr_pkg::ctqr_chem_t'(s.chem) ==
             ctqr_pkg::CTQR_LEAD_ACID)
            next_s.cfg[`CTQR_CFG_TCOMP_BIT] = 1'b1; // see (R11)
         else
            next_s.cfg[`CTQR_CFG_TQ_BIT] = 1'b1; // see (R12)
      end

      // Register writes
      if (reg_wr) begin
         if (reg_addr >= `CTQR_OFS_BP1 && reg_addr <= `CTQR_OFS_BP6)
            next_s.bp[idx] = reg_wdata; // see (R1)
         else if (reg_addr == `CTQR_OFS_VHI)
            next_s.vhi = reg_wdata[9:0]; // see (R5)
         else if (reg_addr == `CTQR_OFS_VLO)
            next_s.vlo = reg_wdata[14:0]; // see (R6)
         else if (reg_addr == `CTQR_OFS_IHI)
            next_s.ihi = reg_wdata[9:0]; // see (R8)
         else if (reg_addr == `CTQR_OFS_ILO)
            next_s.ilo = reg_wdata[14:0]; // see (R8)
         else if (reg_addr == `CTQR_OFS_CFG && s.dflt_cnt != 2'h2)
            next_s.cfg = reg_wdata[2:0]; // see (R10)
      end

      // Region selection, coldest break point checked last so it wins
      if (meas_done) begin
         for (int k = 5; k >= 0; k--) begin
            if (ntc_ratio > s.bp[k])
               r = 3'(k + 1); // see (R23) (R2)
         end
         next_s.region = r;
      end

      // Region codes replace the plain settings
      case (s.region)
         3'h2: begin
            vsel = s.vlo[4:0];
            isel = s.ilo[4:0];
         end
         3'h3: begin
            vsel = s.vlo[9:5];
            isel = s.ilo[9:5];
         end
         3'h4: begin
            vsel = s.vlo[14:10];
            isel = s.ilo[14:10];
         end
         3'h5: begin
            vsel = s.vhi[4:0];
            isel = s.ihi[4:0];
         end
         3'h6: begin
            vsel = s.vhi[9:5];
            isel = s.ihi[9:5];
         end
         default: begin
            vsel = vcharge_setting;
            isel = icharge_target;
         end
      endcase
      next_s.vcode = jact ? vsel : vcharge_setting; // see (R7) (R23)
      next_s.icode = jact ? isel : icharge_target;  // see (R9) (R23)
      next_s.pause = jact && (s.region == `CTQR_REGION_COLD ||
                              s.region == `CTQR_REGION_HOT); // see (R4)

      // Phase timers
      next_s.prev_chg = phase_charging;
      next_s.prev_cv  = phase_cv;
      next_s.prev_abs = phase_absorb;
      next_s.prev_eq  = phase_equalize;
      next_s.tot   = step(s.tot, phase_charging && !is_la, s.prev_chg,
                          sec_tick); // see (R13) (R22)
      next_s.cv    = step(s.cv, phase_cv && !is_la, s.prev_cv,
                          sec_tick); // see (R14) (R22)
      next_s.abs_t = step(s.abs_t, phase_absorb && !is_lion, s.prev_abs,
                          sec_tick); // see (R15) (R22)
      next_s.eq    = step(s.eq, phase_equalize && is_la, s.prev_eq,
                          sec_tick); // see (R16) (R22)
      if (reg_wr && reg_addr == `CTQR_OFS_EQ)
         next_s.eq = reg_wdata; // see (R16)

      // Termination and fault, held until a new charge cycle
      if (phase_charging && !s.prev_chg) begin
         next_s.tterm  = 1'b0;
         next_s.mfault = 1'b0;
      end
      if (!is_la && phase_cv && s.prev_cv && const_volt_limit != 16'h0000 &&
          s.cv >= const_volt_limit)
         next_s.tterm = 1'b1; // see (R20)
      if (!is_la && phase_charging && s.prev_chg && s.tot > max_charge_limit)
         next_s.mfault = 1'b1; // see (R21)

      // One-hot state word, suspension first
      next_s.flags = 11'h000;
      if (s.vnear || s.sysf || suspend_sw)
         next_s.flags[`CTQR_FLG_SUSP_BIT] = 1'b1; // see (R19) (R17)
      else if (phase_equalize && is_la)
         next_s.flags[`CTQR_FLG_EQ_BIT] = 1'b1; // see (R18)
      else if (phase_absorb && !is_lion)
         next_s.flags[`CTQR_FLG_ABS_BIT] = 1'b1; // see (R18)

      // Register reads
      if (reg_rd) begin
         if (reg_addr >= `CTQR_OFS_BP1 && reg_addr <= `CTQR_OFS_BP6)
            next_s.rdata = s.bp[idx];
         else if (reg_addr == `CTQR_OFS_VHI)
            next_s.rdata = {6'h00, s.vhi};
         else if (reg_addr == `CTQR_OFS_VLO)
            next_s.rdata = {1'h0, s.vlo};
         else if (reg_addr == `CTQR_OFS_IHI)
            next_s.rdata = {6'h00, s.ihi};
         else if (reg_addr == `CTQR_OFS_ILO)
            next_s.rdata = {1'h0, s.ilo};
         else if (reg_addr == `CTQR_OFS_CFG)
            next_s.rdata = {13'h0000, s.cfg};
         else if (reg_addr == `CTQR_OFS_TOT)
            next_s.rdata = s.tot;
         else if (reg_addr == `CTQR_OFS_CV)
            next_s.rdata = {5'h00, s.cv[10:0]};
         else if (reg_addr == `CTQR_OFS_ABS)
            next_s.rdata = {5'h00, s.abs_t[10:0]};
         else if (reg_addr == `CTQR_OFS_EQ)
            next_s.rdata = s.eq;
         else if (reg_addr == `CTQR_OFS_FLAGS)
            next_s.rdata = {5'h00, s.flags};
         else
            next_s.rdata = 16'h0000;
      end
   end

   // ======================================================
   // Registers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s        <= '0;
         s.bp     <= {6{`CTQR_RST_BP}};
         s.vlo    <= `CTQR_RST_CODES;
         s.ilo    <= `CTQR_RST_CODES;
         s.cfg    <= `CTQR_RST_CFG;
         s.region <= `CTQR_RST_REGION;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   // ======================================================
   // Outputs
   assign reg_rdata          = s.rdata;
   assign temp_region        = s.region;
   assign charge_pause       = s.pause;
   assign vcharge_code       = s.vcode;
   assign icharge_code       = s.icode;
   assign cx_term_en         = !is_la && s.cfg[`CTQR_CFG_CX_BIT];
   assign temp_comp_en       = is_la && s.cfg[`CTQR_CFG_TCOMP_BIT];
   assign timer_term         = s.tterm;
   assign max_time_fault     = s.mfault;
   assign charge_phase_flags = s.flags;

   // ======================================================
   // Assertions
   sequence bp1_write;
      clk_en && reg_wr && reg_addr == `CTQR_OFS_BP1;
   endsequence

   sequence vhi_read;
      clk_en && reg_rd && reg_addr == `CTQR_OFS_VHI;
   endsequence

   a_bp_write_store: assert property ( // see (R1)
      @(posedge core_clk) disable iff (sys_rst)
      bp1_write |=> s.bp[0] == $past(reg_wdata))
      else $error("break point 1 not stored");

   a_vhi_read_back: assert property ( // see (R5)
      @(posedge core_clk) disable iff (sys_rst)
      vhi_read |=> reg_rdata == {6'h00, $past(s.vhi)})
      else $error("packed voltage codes read wrong");

   a_pause_region: assert property ( // see (R4)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && jact && (s.region == 3'h1 || s.region == 3'h7)
      |=> charge_pause)
      else $error("no pause in region 1 or 7");

   a_volt_region_two: assert property ( // see (R7)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && jact && s.region == 3'h2
      |=> vcharge_code == $past(s.vlo[4:0]))
      else $error("region 2 voltage code not used");

   a_curr_region_six: assert property ( // see (R9)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && jact && s.region == 3'h6
      |=> icharge_code == $past(s.ihi[9:5]) && !charge_pause)
      else $error("region 6 current code not used");

   a_fallback_plain: assert property ( // see (R23)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && !jact |=> vcharge_code == $past(vcharge_setting)
                          && !charge_pause)
      else $error("plain setting not used when disabled");

   a_state_onehot: assert property ( // see (R17)
      @(posedge core_clk) disable iff (sys_rst)
      $onehot0(charge_phase_flags))
      else $error("state word has more than one bit");

   a_suspend_flag: assert property ( // see (R19)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && suspend_sw |=> charge_phase_flags[8])
      else $error("suspend not reported");

   a_cv_entry_clear: assert property ( // see (R22)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && !is_la && phase_cv && !s.prev_cv |=> s.cv == 16'h0000)
      else $error("const_volt_seconds not cleared on entry");

   a_timer_term_set: assert property ( // see (R20)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && !is_la && phase_cv && s.prev_cv
      && const_volt_limit != 16'h0000 && s.cv >= const_volt_limit
      |=> timer_term)
      else $error("timer termination missed");

   a_max_time_fault: assert property ( // see (R21)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && !is_la && phase_charging && s.prev_chg
      && s.tot > max_charge_limit |=> max_time_fault)
      else $error("max charge time fault missed");

   sequence cold_meas;
      clk_en && meas_done && ntc_ratio > s.bp[0];
   endsequence

   a_region_cold: assert property ( // see (R23)
      @(posedge core_clk) disable iff (sys_rst)
      cold_meas |=> temp_region == `CTQR_REGION_COLD)
      else $error("cold ratio not mapped to region 1");

   a_cv_count_step: assert property ( // see (R22)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && !is_la && phase_cv && s.prev_cv && sec_tick
      && s.cv != `CTQR_TIMER_MAX |=> s.cv == $past(s.cv) + 16'h0001)
      else $error("const_volt_seconds did not advance");

   a_eq_saturate: assert property ( // see (R22)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && s.eq == `CTQR_TIMER_MAX && s.prev_eq && phase_equalize
      && !(reg_wr && reg_addr == `CTQR_OFS_EQ) |=> s.eq == `CTQR_TIMER_MAX)
      else $error("equalize timer wrapped");

   a_equalize_flag: assert property ( // see (R18)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && is_la && phase_equalize && !suspend_sw && !s.vnear
      && !s.sysf |=> charge_phase_flags == 11'h400)
      else $error("equalize phase not reported");

   a_absorb_flag: assert property ( // see (R18)
      @(posedge core_clk) disable iff (sys_rst)
      clk_en && !is_lion && phase_absorb && !phase_equalize && !suspend_sw
      && !s.vnear && !s.sysf |=> charge_phase_flags == 11'h200)
      else $error("absorb phase not reported");

   a_enable_freeze: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      !clk_en |=> $stable(s))
      else $error("state moved with clock enable low");

endmodule

/* bench/tb_top.sv */
`timescale 1ns/100ps
`include "ctqr_defines.svh"

module tb_top;
   // ==========================================
   // Stimulus and observed signals
   logic        core_clk                   = 1'b0;
   logic        sys_rst                    = 1'b1;
   logic        clk_en                     = 1'b1;
   logic [7:0]  reg_addr                   = 8'h00;
   logic        reg_wr                     = 1'b0;
   logic [15:0] reg_wdata                  = 16'h0000;
   logic        reg_rd                     = 1'b0;
   logic [1:0]  chem_pins                  = 2'h0;
   logic        vin_near_battery_sense_pin = 1'b0;
   logic        system_fault_pin           = 1'b0;
   logic        suspend_sw                 = 1'b0;
   logic [15:0] ntc_ratio                  = 16'h0000;
   logic        meas_done                  = 1'b0;
   logic        sec_tick                   = 1'b0;
   logic        phase_charging             = 1'b0;
   logic        phase_cv                   = 1'b0;
   logic        phase_absorb               = 1'b0;
   logic        phase_equalize             = 1'b0;
   logic [4:0]  vcharge_setting            = 5'h00;
   logic [4:0]  icharge_target             = 5'h00;
   logic [15:0] const_volt_limit           = 16'h0000;
   logic [15:0] max_charge_limit           = 16'h0000;
   logic [15:0] reg_rdata;
   logic [2:0]  temp_region;
   logic        charge_pause;
   logic [4:0]  vcharge_code;
   logic [4:0]  icharge_code;
   logic        cx_term_en;
   logic        temp_comp_en;
   logic        timer_term;
   logic        max_time_fault;
   logic [10:0] charge_phase_flags;
   logic [9:0]  vhi;
   logic [14:0] vlo;
   logic [9:0]  ihi;
   logic [14:0] ilo;
   logic        rd_pend                    = 1'b0;
   logic [15:0] exp_q[$];
   int          failures                   = 0;
   int          tests_run                  = 0;
   logic [15:0] rt[9] = '{16'h7000, 16'h6000, 16'h5800, 16'h4800,
                          16'h3800, 16'h2800, 16'h1800, 16'h1000,
                          16'h0800};
   logic [2:0]  rg[9] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6,
                          3'h7, 3'h7};

   always #12.5 core_clk = ~core_clk;

   ctqr_regs i_dut (.core_clk, .sys_rst, .clk_en, .reg_addr, .reg_wr,
      .reg_wdata, .reg_rd, .reg_rdata, .chem_pins,
      .vin_near_battery_sense_pin, .system_fault_pin, .suspend_sw,
      .ntc_ratio, .meas_done, .sec_tick, .phase_charging, .phase_cv,
      .phase_absorb, .phase_equalize, .vcharge_setting, .icharge_target,
      .const_volt_limit, .max_charge_limit, .temp_region, .charge_pause,
      .vcharge_code, .icharge_code, .cx_term_en, .temp_comp_en,
      .timer_term, .max_time_fault, .charge_phase_flags);

   // ==========================================
   // Checking and closing
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   always @(posedge core_clk) rd_pend <= reg_rd & clk_en;

   always @(negedge core_clk) begin
      if (rd_pend && exp_q.size() > 0) begin
         check("rdata", reg_rdata, exp_q.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      $display("watchdog expired");
      end_sim;
   end

   // ==========================================
   // Drivers
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
      cyc(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      exp_q.push_back(d);
      cyc(1);
      reg_rd = 1'b0;
      cyc(1);
   endtask

   task automatic tick(input int n);
      sec_tick = 1'b1;
      cyc(n);
      sec_tick = 1'b0;
   endtask

   task automatic do_reset(input logic [1:0] chem);
      sys_rst = 1'b1;
      chem_pins = chem;
      cyc(6);
      sys_rst = 1'b0;
      cyc(6);
   endtask

   function automatic logic [4:0] pick(input logic [9:0] hi,
                                       input logic [14:0] lo,
                                       input logic [2:0] n);
      logic [24:0] all;
      all = {hi, lo};
      return all[5 * (int'(n) - 2) +: 5];
   endfunction

   task automatic meas(input logic [15:0] r, input logic [2:0] n,
                       input logic on);
      logic       p;
      logic [4:0] ev;
      logic [4:0] ei;
      p  = on && (n == 3'h1 || n == 3'h7);
      ev = vcharge_setting;
      ei = icharge_target;
      if (on && !p) begin
         ev = pick(vhi, vlo, n);
         ei = pick(ihi, ilo, n);
      end
      meas_done = 1'b1;
      ntc_ratio = r;
      cyc(1);
      meas_done = 1'b0;
      cyc(2);
      if (on) check("region", 16'(temp_region), 16'(n));
      check("pause", 16'(charge_pause), 16'(p));
      if (!on) begin
         check("vcode", 16'(vcharge_code), 16'(ev));
         check("icode", 16'(icharge_code), 16'(ei));
      end else if (!p) begin
         check("vcode", 16'(vcharge_code), 16'(ev));
         check("icode", 16'(icharge_code), 16'(ei));
      end
   endtask

   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(32'h1193E3C4));
      vhi = 10'($urandom);
      vlo = 15'($urandom);
      ihi = 10'($urandom);
      ilo = 15'($urandom);
      vcharge_setting = 5'($urandom);
      icharge_target = 5'($urandom);
      do_reset(2'h0);
      rd(`CTQR_OFS_CFG, 16'h0001);
      rd(`CTQR_OFS_BP1, 16'h0000);
      check("comp", 16'(temp_comp_en), 16'h0000);
      $display("test defaults done");
      for (int k = 0; k < 6; k++) begin
         wr(8'(`CTQR_OFS_BP1 + k), 16'(16'h6000 - 16'h1000 * k));
      end
      for (int k = 0; k < 6; k++) begin
         rd(8'(`CTQR_OFS_BP1 + k), 16'(16'h6000 - 16'h1000 * k));
      end
      wr(`CTQR_OFS_VHI, {6'h3F, vhi});
      wr(`CTQR_OFS_VLO, {1'b1, vlo});
      wr(`CTQR_OFS_IHI, {6'h3F, ihi});
      wr(`CTQR_OFS_ILO, {1'b1, ilo});
      rd(`CTQR_OFS_VHI, {6'h00, vhi});
      rd(`CTQR_OFS_VLO, {1'b0, vlo});
      rd(`CTQR_OFS_IHI, {6'h00, ihi});
      rd(`CTQR_OFS_ILO, {1'b0, ilo});
      wr(`CTQR_OFS_TOT, 16'hFFFF);
      wr(`CTQR_OFS_FLAGS, 16'hFFFF);
      rd(`CTQR_OFS_TOT, 16'h0000);
      rd(`CTQR_OFS_FLAGS, 16'h0000);
      rd(8'h50, 16'h0000);
      $display("test registers done");
      for (int k = 0; k < 9; k++) begin
         meas(rt[k], rg[k], 1'b1);
      end
      wr(`CTQR_OFS_CFG, 16'h0004);
      meas(16'h7000, 3'h1, 1'b0);
      check("cx", 16'(cx_term_en), 16'h0001);
      check("comp", 16'(temp_comp_en), 16'h0000);
      clk_en = 1'b0;
      wr(`CTQR_OFS_BP1, 16'h1234);
      clk_en = 1'b1;
      rd(`CTQR_OFS_BP1, 16'h6000);
      $display("test regions done");
      const_volt_limit = 16'h0003;
      max_charge_limit = 16'h0002;
      phase_charging = 1'b1;
      cyc(1);
      {phase_cv, phase_absorb, phase_equalize} = 3'h7;
      cyc(1);
      tick(2);
      cyc(2);
      check("term", 16'(timer_term), 16'h0000);
      check("fault", 16'(max_time_fault), 16'h0000);
      tick(1);
      cyc(2);
      check("term", 16'(timer_term), 16'h0001);
      check("fault", 16'(max_time_fault), 16'h0001);
      check("flags", 16'(charge_phase_flags), 16'h0000);
      rd(`CTQR_OFS_TOT, 16'h0003);
      rd(`CTQR_OFS_CV, 16'h0003);
      rd(`CTQR_OFS_ABS, 16'h0000);
      rd(`CTQR_OFS_EQ, 16'h0000);
      const_volt_limit = 16'h0000;
      phase_charging = 1'b0;
      cyc(1);
      phase_charging = 1'b1;
      cyc(2);
      check("fault", 16'(max_time_fault), 16'h0000);
      rd(`CTQR_OFS_TOT, 16'h0000);
      {phase_charging, phase_cv, phase_absorb, phase_equalize} = 4'h0;
      $display("test timers done");
      for (int c = 0; c < 3; c++) begin
         {suspend_sw, system_fault_pin, vin_near_battery_sense_pin} = 3'(1 << c);
         cyc(5);
         check("flags", 16'(charge_phase_flags), 16'h0100);
         {suspend_sw, system_fault_pin, vin_near_battery_sense_pin} = 3'h0;
         cyc(5);
         check("flags", 16'(charge_phase_flags), 16'h0000);
      end
      $display("test suspend done");
      do_reset(2'h2);
      rd(`CTQR_OFS_CFG, 16'h0002);
      check("comp", 16'(temp_comp_en), 16'h0001);
      wr(`CTQR_OFS_CFG, 16'h0007);
      check("cx", 16'(cx_term_en), 16'h0000);
      meas(16'h7000, 3'h1, 1'b0);
      {phase_absorb, phase_equalize} = 2'h3;
      cyc(1);
      tick(2);
      cyc(1);
      check("flags", 16'(charge_phase_flags), 16'h0400);
      rd(`CTQR_OFS_EQ, 16'h0002);
      rd(`CTQR_OFS_ABS, 16'h0002);
      phase_equalize = 1'b0;
      cyc(2);
      check("flags", 16'(charge_phase_flags), 16'h0200);
      suspend_sw = 1'b1;
      cyc(2);
      check("flags", 16'(charge_phase_flags), 16'h0100);
      wr(`CTQR_OFS_EQ, 16'h0005);
      rd(`CTQR_OFS_EQ, 16'h0005);
      phase_equalize = 1'b1;
      cyc(1);
      wr(`CTQR_OFS_EQ, 16'hFFFF);
      tick(2);
      rd(`CTQR_OFS_EQ, 16'hFFFF);
      $display("test lead acid done");
      end_sim;
   end
endmodule
